// ==== design/sacc_pkg.sv ====
package sacc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_MODE_SEL   = 8'h00;
	localparam logic [7:0] OFS_PIN_FUNC   = 8'h04;
	localparam logic [7:0] OFS_CLK_SEL    = 8'h08;
	localparam logic [7:0] OFS_INT_CTRL   = 8'h0C;
	localparam logic [7:0] OFS_INSTR      = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;
	localparam logic [7:0] OFS_ACC_PAIR   = 8'h18;
	localparam logic [7:0] OFS_RESULT     = 8'h1C;
	localparam logic [7:0] OFS_CMP_REG    = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_BIT       = 3;
	localparam int CLK_SRC_BIT    = 2;
	localparam int INT_EN_BIT     = 2;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_FLAG_BIT    = 1;
	localparam int ST_SKIP_BIT    = 2;
	localparam int RESULT_MSB     = 9;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [9:0] RST_RESULT = 10'h000;
	localparam logic [7:0] RST_CMP    = 8'h00;

	// ----------------------------------------------------------------
	// Instruction opcodes written to the instruction register
	// ----------------------------------------------------------------
	localparam logic [2:0] OP_CONVERT_START = 3'h1;
	localparam logic [2:0] OP_SKIP_IF_DONE  = 3'h2;
	localparam logic [2:0] OP_LOW_TO_ACC    = 3'h3;
	localparam logic [2:0] OP_HIGH_TO_PAIR  = 3'h4;
	localparam logic [2:0] OP_PAIR_TO_CMP   = 3'h5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CORE_CLK_PERIOD_PS = 5000;
	localparam int MACHINE_CYCLE_NS   = 500;
	localparam logic [7:0] INST_CYCLES = 8'(MACHINE_CYCLE_NS * 1000 / CORE_CLK_PERIOD_PS);
	localparam logic [1:0] SETUP_MACHINE_CYCLES = 2'h2;
	localparam logic [7:0] DIV_RATIO_0 = 8'h06;
	localparam logic [7:0] DIV_RATIO_1 = 8'h0C;
	localparam logic [7:0] DIV_RATIO_2 = 8'h18;
	localparam logic [7:0] DIV_RATIO_3 = 8'h30;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SETUP = 3'b010,
		ST_TRIAL = 3'b100
	} sacc_state_t;

endpackage : sacc_pkg

// ==== design/sacc_sar_step.sv ====
`timescale 1ns/1ps
`default_nettype none

// One approximation step: fix the trial bit from the comparator, then raise the next lower bit.
module sacc_sar_step (
	input  wire logic [9:0] res_in,
	input  wire logic [3:0] idx,
	input  wire logic       comp_high,
	output logic [9:0]      res_out
);
	always_comb begin
		res_out      = res_in;
		res_out[idx] = comp_high;
		if (idx != 4'h0) begin
			res_out[idx - 4'h1] = 1'b1;
		end
	end

endmodule : sacc_sar_step

`default_nettype wire

// ==== design/sacc_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none

// Counts input ticks and pulses once every limit ticks; restart realigns the phase.
module sacc_tick_div (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       restart,
	input  wire logic       tick_in,
	input  wire logic [7:0] limit,
	output logic            tick_out
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       last;

	always_comb begin
		last  = (cnt_q >= limit - 8'h01);
		cnt_d = cnt_q;
		if (restart) begin
			cnt_d = 8'h00;
		end else if (tick_in) begin
			cnt_d = last ? 8'h00 : cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick_out = tick_in & last & ~restart;

endmodule : sacc_tick_div

`default_nettype wire

// ==== design/sacc_top.sv ====
// Function
// - Start in conversion mode clears result
// - Set top bit, compare threshold with input
// - Keep bit if below input, else clear
// - Repeat down to bit zero, ten trials
// - Finish after two machine cycles plus trials
// - On completion set flag, raise interrupt request
// - Conversion mode threshold equals result register
// - Mode bit three selects comparator mode
// - Pair transfer loads compare register aux:acc
// - Compare register survives mode switching
// - Compare register accessible only in comparator mode
// - Comparator threshold from compare register over 256
// - Comparator mode flag means input below threshold
// - Flag clears on interrupt accept or skip
// - Comparison ends after two cycles plus one
// - Low bits to acc top, lower zero
// - Mode switch may set flag; skip clears it
// - Pin-function bits 0-2 enable inputs 0-2; bit 2 also enables input 3
// - Conversion clock can be instruction clock/6
// - Select codes 000-011 route inputs, else none
// - High bits to aux and acc pair
// - Clock source bit plus two ratio bits
`timescale 1ns/1ps
`default_nettype none

module sacc_top (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        COMP_IN,
	input  wire logic        RING_CLK,
	input  wire logic        INT_ACK,
	output logic             IRQ_REQ,
	output logic      [9:0]  DAC_CODE,
	output logic      [1:0]  ANALOG_SEL,
	output logic             ANALOG_SEL_VALID,
	output logic      [3:0]  PIN_ANALOG_EN,
	output logic             BUSY
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic comp_s1_q;
	logic comp_s2_q;
	logic ring_s1_q;
	logic ring_s2_q;
	logic ring_s3_q;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			comp_s1_q <= 1'b0;
			comp_s2_q <= 1'b0;
			ring_s1_q <= 1'b0;
			ring_s2_q <= 1'b0;
			ring_s3_q <= 1'b0;
		end else begin
			comp_s1_q <= COMP_IN;
			comp_s2_q <= comp_s1_q;
			ring_s1_q <= RING_CLK;
			ring_s2_q <= ring_s1_q;
			ring_s3_q <= ring_s2_q;
		end
	end

	// ----------------------------------------------------------------
	// Registers and engine state
	// ----------------------------------------------------------------
	logic [3:0]                mode_input_select_reg_q, mode_input_select_reg_d;
	logic [3:0]                analog_pin_function_reg_q, analog_pin_function_reg_d;
	logic [3:0]                conv_clock_select_reg_q, conv_clock_select_reg_d;
	logic [3:0]                interrupt_control_reg_q, interrupt_control_reg_d;
	logic [3:0]                acc_q, acc_d;
	logic [3:0]                aux_q, aux_d;
	logic [9:0]                result_q, result_d;
	logic [7:0]                cmp_reg_q, cmp_reg_d;
	logic                      done_compare_flag_q, done_compare_flag_d;
	logic                      skip_q, skip_d;
	logic [1:0]                setup_cnt_q, setup_cnt_d;
	logic [3:0]                bit_idx_q, bit_idx_d;
	sacc_pkg::sacc_state_t     state_q, state_d;

	logic        cmp_mode;
	logic        wr_en;
	logic        start;
	logic        inst_tick;
	logic        src_tick;
	logic        conversion_clock;
	logic [7:0]  conv_limit;
	logic [9:0]  step_res;
	logic        trial_go;

	// ----------------------------------------------------------------
	// Bus
	// ----------------------------------------------------------------
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;

	assign cmp_mode = mode_input_select_reg_q[sacc_pkg::MODE_BIT];
	assign wr_en    = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_q & WB_SEL_I[0];
	assign start    = wr_en && (WB_ADR_I == sacc_pkg::OFS_INSTR)
		&& (WB_DAT_I[2:0] == sacc_pkg::OP_CONVERT_START) && (state_q == sacc_pkg::ST_IDLE);

	// Ratio decode picks the conversion clock divider
	function automatic logic [7:0] ratio_of(input logic [1:0] sel);
		logic [7:0] r;
		r = sacc_pkg::DIV_RATIO_0;
		if (sel == 2'h1) begin
			r = sacc_pkg::DIV_RATIO_1;
		end else if (sel == 2'h2) begin
			r = sacc_pkg::DIV_RATIO_2;
		end else if (sel == 2'h3) begin
			r = sacc_pkg::DIV_RATIO_3;
		end
		return r;
	endfunction : ratio_of

	// ----------------------------------------------------------------
	// Clocking: instruction clock and conversion clock ticks
	// ----------------------------------------------------------------
	sacc_tick_div u_inst_div (
		.clk      (CORE_CLK),
		.rst      (RST),
		.restart  (start),
		.tick_in  (1'b1),
		.limit    (sacc_pkg::INST_CYCLES),
		.tick_out (inst_tick)
	);

	// Source is the instruction clock or the rising edge of the on-chip oscillator
	assign src_tick   = conv_clock_select_reg_q[sacc_pkg::CLK_SRC_BIT] ? (ring_s2_q & ~ring_s3_q)
		: inst_tick;
	assign conv_limit = ratio_of(conv_clock_select_reg_q[1:0]);

	// Divider phase starts with the first trial; a start-aligned phase would shorten that trial by the setup time
	assign trial_go = (state_q == sacc_pkg::ST_SETUP) && inst_tick
		&& (setup_cnt_q + 2'h1 == sacc_pkg::SETUP_MACHINE_CYCLES);

	sacc_tick_div u_conv_div (
		.clk      (CORE_CLK),
		.rst      (RST),
		.restart  (trial_go),
		.tick_in  (src_tick),
		.limit    (conv_limit),
		.tick_out (conversion_clock)
	);

	sacc_sar_step u_step (
		.res_in    (result_q),
		.idx       (bit_idx_q),
		.comp_high (comp_s2_q),
		.res_out   (step_res)
	);

	// ----------------------------------------------------------------
	// Engine and register next-state
	// ----------------------------------------------------------------
	always_comb begin
		mode_input_select_reg_d   = mode_input_select_reg_q;
		analog_pin_function_reg_d = analog_pin_function_reg_q;
		conv_clock_select_reg_d   = conv_clock_select_reg_q;
		interrupt_control_reg_d   = interrupt_control_reg_q;
		acc_d                     = acc_q;
		aux_d                     = aux_q;
		result_d                  = result_q;
		cmp_reg_d                 = cmp_reg_q;
		done_compare_flag_d       = done_compare_flag_q;
		skip_d                    = skip_q;
		setup_cnt_d               = setup_cnt_q;
		bit_idx_d                 = bit_idx_q;
		state_d                   = state_q;

		// Clears first, so any set below in the same cycle wins
		if (INT_ACK && interrupt_control_reg_q[sacc_pkg::INT_EN_BIT]) begin
			done_compare_flag_d = 1'b0;
		end

		if (wr_en) begin
			if (WB_ADR_I == sacc_pkg::OFS_MODE_SEL) begin
				mode_input_select_reg_d = WB_DAT_I[3:0];
				// Leaving comparator mode can leave the flag set spuriously
				if (cmp_mode && !WB_DAT_I[sacc_pkg::MODE_BIT]) begin
					done_compare_flag_d = 1'b1;
				end
			end else if (WB_ADR_I == sacc_pkg::OFS_PIN_FUNC) begin
				analog_pin_function_reg_d = WB_DAT_I[3:0];
			end else if (WB_ADR_I == sacc_pkg::OFS_CLK_SEL) begin
				conv_clock_select_reg_d = WB_DAT_I[3:0];
			end else if (WB_ADR_I == sacc_pkg::OFS_INT_CTRL) begin
				interrupt_control_reg_d = WB_DAT_I[3:0];
			end else if (WB_ADR_I == sacc_pkg::OFS_ACC_PAIR) begin
				acc_d = WB_DAT_I[3:0];
				aux_d = WB_DAT_I[7:4];
			end else if (WB_ADR_I == sacc_pkg::OFS_CMP_REG) begin
				if (cmp_mode) begin
					cmp_reg_d = WB_DAT_I[7:0];
				end
			end else if (WB_ADR_I == sacc_pkg::OFS_INSTR) begin
				if (WB_DAT_I[2:0] == sacc_pkg::OP_SKIP_IF_DONE) begin
					skip_d = done_compare_flag_q;
					if (done_compare_flag_q) begin
						done_compare_flag_d = 1'b0;
					end
				end else if (WB_DAT_I[2:0] == sacc_pkg::OP_LOW_TO_ACC) begin
					acc_d = {result_q[1:0], 2'b00};
				end else if (WB_DAT_I[2:0] == sacc_pkg::OP_HIGH_TO_PAIR) begin
					aux_d = result_q[9:6];
					acc_d = result_q[5:2];
				end else if (WB_DAT_I[2:0] == sacc_pkg::OP_PAIR_TO_CMP) begin
					if (cmp_mode) begin
						cmp_reg_d = {aux_q, acc_q};
					end
				end
			end
		end

		case (state_q)
			sacc_pkg::ST_IDLE: begin
				if (start) begin
					if (!cmp_mode) begin
						result_d = sacc_pkg::RST_RESULT;
					end
					setup_cnt_d = 2'h0;
					state_d     = sacc_pkg::ST_SETUP;
				end
			end
			sacc_pkg::ST_SETUP: begin
				// Two machine cycles of setup before the first trial
				if (inst_tick) begin
					setup_cnt_d = setup_cnt_q + 2'h1;
					if (setup_cnt_q + 2'h1 == sacc_pkg::SETUP_MACHINE_CYCLES) begin
						bit_idx_d = 4'(sacc_pkg::RESULT_MSB);
						if (!cmp_mode) begin
							result_d = 10'h200;
						end
						state_d = sacc_pkg::ST_TRIAL;
					end
				end
			end
			sacc_pkg::ST_TRIAL: begin
				// Comparator is sampled at the end of each conversion-clock period
				if (conversion_clock) begin
					if (cmp_mode) begin
						if (!comp_s2_q) begin
							done_compare_flag_d = 1'b1;
						end
						state_d = sacc_pkg::ST_IDLE;
					end else begin
						result_d = step_res;
						if (bit_idx_q == 4'h0) begin
							done_compare_flag_d = 1'b1;
							state_d             = sacc_pkg::ST_IDLE;
						end else begin
							bit_idx_d = bit_idx_q - 4'h1;
						end
					end
				end
			end
			default: begin
				state_d = sacc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			mode_input_select_reg_q   <= sacc_pkg::RST_NIBBLE;
			analog_pin_function_reg_q <= sacc_pkg::RST_NIBBLE;
			conv_clock_select_reg_q   <= sacc_pkg::RST_NIBBLE;
			interrupt_control_reg_q   <= sacc_pkg::RST_NIBBLE;
			acc_q                     <= sacc_pkg::RST_NIBBLE;
			aux_q                     <= sacc_pkg::RST_NIBBLE;
			result_q                  <= sacc_pkg::RST_RESULT;
			cmp_reg_q                 <= sacc_pkg::RST_CMP;
			done_compare_flag_q       <= 1'b0;
			skip_q                    <= 1'b0;
			setup_cnt_q               <= 2'h0;
			bit_idx_q                 <= 4'h0;
			state_q                   <= sacc_pkg::ST_IDLE;
		end else begin
			mode_input_select_reg_q   <= mode_input_select_reg_d;
			analog_pin_function_reg_q <= analog_pin_function_reg_d;
			conv_clock_select_reg_q   <= conv_clock_select_reg_d;
			interrupt_control_reg_q   <= interrupt_control_reg_d;
			acc_q                     <= acc_d;
			aux_q                     <= aux_d;
			result_q                  <= result_d;
			cmp_reg_q                 <= cmp_reg_d;
			done_compare_flag_q       <= done_compare_flag_d;
			skip_q                    <= skip_d;
			setup_cnt_q               <= setup_cnt_d;
			bit_idx_q                 <= bit_idx_d;
			state_q                   <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Bus read path; unmapped addresses acknowledge with zero
	// ----------------------------------------------------------------
	always_comb begin
		ack_d   = WB_CYC_I & WB_STB_I & ~ack_q;
		rdata_d = 32'h0000_0000;
		if (WB_ADR_I == sacc_pkg::OFS_MODE_SEL) begin
			rdata_d[3:0] = mode_input_select_reg_q;
		end else if (WB_ADR_I == sacc_pkg::OFS_PIN_FUNC) begin
			rdata_d[3:0] = analog_pin_function_reg_q;
		end else if (WB_ADR_I == sacc_pkg::OFS_CLK_SEL) begin
			rdata_d[3:0] = conv_clock_select_reg_q;
		end else if (WB_ADR_I == sacc_pkg::OFS_INT_CTRL) begin
			rdata_d[3:0] = interrupt_control_reg_q;
		end else if (WB_ADR_I == sacc_pkg::OFS_STATUS) begin
			rdata_d[sacc_pkg::ST_BUSY_BIT] = (state_q != sacc_pkg::ST_IDLE);
			rdata_d[sacc_pkg::ST_FLAG_BIT] = done_compare_flag_q;
			rdata_d[sacc_pkg::ST_SKIP_BIT] = skip_q;
		end else if (WB_ADR_I == sacc_pkg::OFS_ACC_PAIR) begin
			rdata_d[7:0] = {aux_q, acc_q};
		end else if (WB_ADR_I == sacc_pkg::OFS_RESULT) begin
			rdata_d[9:0] = result_q;
		end else if (WB_ADR_I == sacc_pkg::OFS_CMP_REG) begin
			// Hidden outside comparator mode; the value itself is kept
			rdata_d[7:0] = cmp_mode ? cmp_reg_q : 8'h00;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdata_q;
	// Interrupt request only when interrupt use, not skip use, is selected
	assign IRQ_REQ  = done_compare_flag_q & interrupt_control_reg_q[sacc_pkg::INT_EN_BIT];
	// Comparator code n/256 equals 4n/1024 on the 10-bit DAC
	assign DAC_CODE = cmp_mode ? {cmp_reg_q, 2'b00} : result_q;
	assign ANALOG_SEL       = mode_input_select_reg_q[1:0];
	assign ANALOG_SEL_VALID = ~mode_input_select_reg_q[2];
	assign PIN_ANALOG_EN    = {analog_pin_function_reg_q[2], analog_pin_function_reg_q[2:0]};
	assign BUSY             = (state_q != sacc_pkg::ST_IDLE);

endmodule : sacc_top

`default_nettype wire

// ==== verification/sacc_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Ideal comparator behind the on-chip DA converter, plus a free-running oscillator
module sacc_analog_model (
	input  wire logic [9:0]  dac_code,
	input  wire logic [1:0]  sel,
	input  wire logic        sel_valid,
	input  wire logic [3:0]  pin_en,
	input  wire logic [43:0] vin_all,
	output logic             comp,
	output var logic         ring_clk
);
	logic [10:0] vin;

	// Input voltage in steps of supply/1024, so 1024 means above every code
	assign vin  = vin_all[11 * sel +: 11];
	// Unrouted or disabled pin reads as ground: never above the threshold
	assign comp = sel_valid && pin_en[sel] && ({1'b0, dac_code} < vin);

	initial begin
		ring_clk = 1'b0;
		forever #18.5 ring_clk = ~ring_clk;
	end
endmodule : sacc_analog_model

`default_nettype wire

// ==== verification/sacc_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module sacc_top_assertions (
	input wire logic        CORE_CLK,
	input wire logic        RST,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        INT_ACK,
	input wire logic        IRQ_REQ,
	input wire logic [9:0]  DAC_CODE,
	input wire logic        BUSY
);
	// --------------------------------
	// Shadow of control fields
	// --------------------------------
	logic        req;
	logic        wr;
	logic        start;
	logic        mode_q;
	logic        ien_q;
	logic [2:0]  clk_q;
	logic [15:0] cnt_q;

	assign req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wr    = req && WB_WE_I && WB_SEL_I[0];
	assign start = wr && WB_ADR_I == sacc_pkg::OFS_INSTR && WB_DAT_I[2:0] == sacc_pkg::OP_CONVERT_START && !BUSY;

	// Busy length is counted here so the timing checks stay one-liners
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			mode_q <= 1'b0;
			ien_q  <= 1'b0;
			clk_q  <= 3'h0;
			cnt_q  <= 16'h0000;
		end else begin
			if (wr && WB_ADR_I == sacc_pkg::OFS_MODE_SEL) mode_q <= WB_DAT_I[3];
			if (wr && WB_ADR_I == sacc_pkg::OFS_INT_CTRL) ien_q <= WB_DAT_I[2];
			if (wr && WB_ADR_I == sacc_pkg::OFS_CLK_SEL) clk_q <= WB_DAT_I[2:0];
			cnt_q <= BUSY ? cnt_q + 16'h0001 : 16'h0000;
		end
	end

	// --------------------------------
	// Properties
	// --------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	property p_start_clear;
		start && !mode_q |-> ##2 DAC_CODE == 10'h000;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("result not cleared at start");

	property p_top_bit;
		start && !mode_q |-> ##[195:215] DAC_CODE == 10'h200;
	endproperty
	a_top_bit: assert property (p_top_bit) else $error("top trial bit not raised after setup");

	property p_conv_time;
		$fell(BUSY) && !mode_q && clk_q == 3'h0 |-> cnt_q >= 16'h1810 && cnt_q <= 16'h1860;
	endproperty
	a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

	property p_cmp_time;
		$fell(BUSY) && mode_q && clk_q == 3'h0 |-> cnt_q >= 16'h030C && cnt_q <= 16'h0334;
	endproperty
	a_cmp_time: assert property (p_cmp_time) else $error("comparison length wrong");

	property p_irq;
		$fell(BUSY) && !mode_q && ien_q |-> ##[0:1] IRQ_REQ;
	endproperty
	a_irq: assert property (p_irq) else $error("no request after conversion");

	property p_cmp_dac;
		mode_q |-> DAC_CODE[1:0] == 2'b00;
	endproperty
	a_cmp_dac: assert property (p_cmp_dac) else $error("comparator threshold not 8 bit");

	property p_ack_clear;
		INT_ACK && ien_q && !BUSY |-> ##[1:2] !IRQ_REQ;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("accept did not clear flag");

	property p_cmp_hidden;
		req && !WB_WE_I && WB_ADR_I == sacc_pkg::OFS_CMP_REG && !mode_q |=> WB_ACK_O && WB_DAT_O == 32'h0000_0000;
	endproperty
	a_cmp_hidden: assert property (p_cmp_hidden) else $error("compare value visible in conversion mode");

	c_conv: cover property ($fell(BUSY) && !mode_q);
	c_cmp: cover property ($fell(BUSY) && mode_q);
	c_ack: cover property (INT_ACK && ien_q);
endmodule : sacc_top_assertions

bind sacc_top sacc_top_assertions u_chk (
	.CORE_CLK(CORE_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .INT_ACK(INT_ACK), .IRQ_REQ(IRQ_REQ), .DAC_CODE(DAC_CODE), .BUSY(BUSY)
);

`default_nettype wire

// ==== verification/sacc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module sacc_top_tb;
	logic        clk;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat;
	logic [31:0] dout;
	logic        ack;
	logic        comp;
	logic        ring;
	logic        int_ack;
	logic        irq;
	logic [9:0]  dac;
	logic [1:0]  asel;
	logic        asel_v;
	logic [3:0]  pin_en;
	logic        busy;
	logic [43:0] vin_all;
	logic [31:0] rd;
	logic [9:0]  e;
	int          error_cnt;
	int          comparisons;

	sacc_top DUT (
		.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .COMP_IN(comp),
		.RING_CLK(ring), .INT_ACK(int_ack), .IRQ_REQ(irq), .DAC_CODE(dac), .ANALOG_SEL(asel),
		.ANALOG_SEL_VALID(asel_v), .PIN_ANALOG_EN(pin_en), .BUSY(busy)
	);

	sacc_analog_model u_ana (
		.dac_code(dac), .sel(asel), .sel_valid(asel_v), .pin_en(pin_en), .vin_all(vin_all),
		.comp(comp), .ring_clk(ring)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// --------------------------------
	// Bus and check tasks
	// --------------------------------
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		// Only the watchdog ends a wait for the acknowledge
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb_cycle

	task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
		wb_cycle(1'b1, a, d);
	endtask : wb_write

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		wb_cycle(1'b0, a, 32'h0000_0000);
		chk(exp, rd);
	endtask : chk_rd

	task automatic run(input logic [2:0] op);
		wb_write(sacc_pkg::OFS_INSTR, 32'(op));
	endtask : run

	// Polls status instead of assuming a count: the length is the checker's business
	task automatic wait_idle();
		do wb_cycle(1'b0, sacc_pkg::OFS_STATUS, 32'h0000_0000);
		while (rd[sacc_pkg::ST_BUSY_BIT] !== 1'b0);
	endtask : wait_idle

	function automatic logic [9:0] sar_expect(input logic [10:0] v);
		logic [9:0] c;
		c = 10'h000;
		for (int b = 9; b >= 0; b--)
			if ({1'b0, c | (10'h001 << b)} < v) c = c | (10'h001 << b);
		return c;
	endfunction : sar_expect

	task automatic test_done();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		test_done();
	end

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		error_cnt   = 0;
		comparisons = 0;
		rst         = 1'b1;
		{cyc, stb, we, int_ack} = 4'h0;
		adr     = 8'h00;
		dat     = 32'h0000_0000;
		sel     = 4'hF;
		vin_all = {11'h001, 11'h000, 11'h400, 11'h2A7};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 10; i++) chk_rd(8'(i * 4), 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			wb_write(sacc_pkg::OFS_MODE_SEL, 32'(i));
			chk(32'({2'(i), ~i[2]}), 32'({asel, asel_v}));
			wb_write(sacc_pkg::OFS_PIN_FUNC, 32'(i));
			chk(32'({i[2], i[2], i[1], i[0]}), 32'(pin_en));
		end
		wb_write(sacc_pkg::OFS_CLK_SEL, 32'h0000_0000);
		wb_write(sacc_pkg::OFS_INT_CTRL, 32'h0000_0004);
		for (int i = 0; i < 4; i++) begin
			if (i == 2) continue;
			e = sar_expect(vin_all[11 * i +: 11]);
			wb_write(sacc_pkg::OFS_MODE_SEL, 32'(i));
			run(sacc_pkg::OP_CONVERT_START);
			run(sacc_pkg::OP_CONVERT_START);
			wait_idle();
			chk_rd(sacc_pkg::OFS_RESULT, 32'(e));
			chk(32'h0000_0001, 32'(irq));
			@(posedge clk);
			int_ack <= 1'b1;
			@(posedge clk);
			int_ack <= 1'b0;
			chk_rd(sacc_pkg::OFS_STATUS, 32'h0000_0000);
			if (i == 0) begin
				wb_write(sacc_pkg::OFS_ACC_PAIR, 32'h0000_00FF);
				run(sacc_pkg::OP_LOW_TO_ACC);
				chk_rd(sacc_pkg::OFS_ACC_PAIR, 32'({4'hF, e[1:0], 2'b00}));
				run(sacc_pkg::OP_HIGH_TO_PAIR);
				chk_rd(sacc_pkg::OFS_ACC_PAIR, 32'(e[9:2]));
			end
		end
		wb_write(sacc_pkg::OFS_INT_CTRL, 32'h0000_0000);
		wb_write(sacc_pkg::OFS_MODE_SEL, 32'h0000_0008);
		for (int i = 0; i < 3; i++) begin
			e = (i == 0) ? 10'h280 : 10'h2C0;
			if (i == 2) wb_write(sacc_pkg::OFS_CLK_SEL, 32'h0000_0007);
			wb_write(sacc_pkg::OFS_ACC_PAIR, 32'(e[9:2]));
			run(sacc_pkg::OP_PAIR_TO_CMP);
			chk_rd(sacc_pkg::OFS_CMP_REG, 32'(e[9:2]));
			chk(32'(e), 32'(dac));
			run(sacc_pkg::OP_CONVERT_START);
			wait_idle();
			chk(32'({i == 2, vin_all[10:0] < {1'b0, e}, 1'b0}), rd);
			run(sacc_pkg::OP_SKIP_IF_DONE);
			chk_rd(sacc_pkg::OFS_STATUS, 32'({i != 0, 2'b00}));
		end
		wb_write(sacc_pkg::OFS_CLK_SEL, 32'h0000_0000);
		wb_write(sacc_pkg::OFS_MODE_SEL, 32'h0000_0000);
		run(sacc_pkg::OP_SKIP_IF_DONE);
		chk_rd(sacc_pkg::OFS_STATUS, 32'h0000_0004);
		chk_rd(sacc_pkg::OFS_CMP_REG, 32'h0000_0000);
		wb_write(sacc_pkg::OFS_CMP_REG, 32'h0000_0055);
		wb_write(sacc_pkg::OFS_MODE_SEL, 32'h0000_0008);
		chk_rd(sacc_pkg::OFS_CMP_REG, 32'h0000_00B0);
		test_done();
	end
endmodule : sacc_top_tb

`default_nettype wire
